// ===== sro_cfg.svh
`ifndef SRO_CFG_SVH
`define SRO_CFG_SVH

// ----------------------------------------------------------------------------
// Bank codes on the control port
// ----------------------------------------------------------------------------
`define SRO_CODE_WRITE 8'h02
`define SRO_CODE_READ  8'h82

// ----------------------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------------------
`define SRO_ADDR_HOLD  16'h3001
`define SRO_ADDR_RES   16'h3005
`define SRO_ADDR_FIXA  16'h3006
`define SRO_ADDR_DIR   16'h3007
`define SRO_ADDR_FIXB  16'h3008
`define SRO_ADDR_RATE  16'h3009
`define SRO_ADDR_BLKL  16'h300a
`define SRO_ADDR_BLKH  16'h300b
`define SRO_ADDR_TUNE  16'h3011
`define SRO_ADDR_GAIN  16'h3014

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SRO_BIT_HOLD   0
`define SRO_BIT_RES    0
`define SRO_BIT_VFLIP  0
`define SRO_BIT_HFLIP  1
`define SRO_WIN_LSB    4
`define SRO_WIN_MSB    6
`define SRO_RATE_MSB   1
`define SRO_BIT_CGAIN  4
`define SRO_BIT_BLKHI  0

// ----------------------------------------------------------------------------
// Reset values and legal window codes
// ----------------------------------------------------------------------------
`define SRO_RST_HOLD   1'b0
`define SRO_RST_RES    1'b1
`define SRO_RST_FLIP   1'b0
`define SRO_RST_WIN    3'h0
`define SRO_RST_RATE   2'h1
`define SRO_RST_CGAIN  1'b0
`define SRO_RST_BLK    9'h0f0
`define SRO_RST_GAIN   8'h00
`define SRO_RST_FIXA   8'h00
`define SRO_RST_FIXB   8'ha0
`define SRO_RST_TUNE   8'h00
`define SRO_WIN_FULL   3'h0
`define SRO_WIN_720    3'h1
`define SRO_WIN_CROP   3'h4

`endif

// ===== sro_pkg.sv
package sro_pkg;

   // -------------------------------------------------------------------------
   // Decoded access from the serial control port
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  chipCode;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } sro_req_t;

   // -------------------------------------------------------------------------
   // Frame-synchronous readout settings
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic       convResolutionSel;
      logic       verticalFlip;
      logic       horizontalFlip;
      logic [2:0] windowSelect;
      logic [1:0] rateSelect;
      logic       convGainSelect;
      logic [8:0] blackOffset;
      logic [7:0] totalGain;
   } sro_settings_t;

endpackage

// ===== sro_config_regs.sv
// Behaviour
// - Writes use code 02h, reads use 82h.
// - Bit 0 of 3005h: 10/12-bit, resets 1.
// - 3007h bits 0/1 flip vertical/horizontal readout.
// - Window select codes 0, 1, 4 only.
// - 3009h rate select resets 1, bit 4 gain.
// - Nine-bit black offset split, resets 0F0h.
// - Total gain byte at 3014h, 0.3 dB steps.
// - Hold blocks transfer of pending frame settings.
`include "sro_cfg.svh"

module sro_config_regs (
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   input  wire sro_pkg::sro_req_t      req,
   input  wire logic                   frameStart,
   output logic [7:0]                  rdData,
   output logic                        rdValid,
   output logic                        holdActive,
   output logic [7:0]                  tuningValue,
   output sro_pkg::sro_settings_t      settings
);

   // ------------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------------
   sro_pkg::sro_settings_t shadow_r, shadow_nxt;
   sro_pkg::sro_settings_t active_r, active_nxt;
   logic [7:0]             fixA_r, fixA_nxt;
   logic [7:0]             fixB_r, fixB_nxt;
   logic [7:0]             tune_r, tune_nxt;
   logic                   hold_r, hold_nxt;
   logic [7:0]             rdData_r, rdData_nxt;
   logic                   rdValid_r, rdValid_nxt;
   logic                   wrHit;
   logic                   rdHit;

   assign wrHit = req.wr && (req.chipCode == `SRO_CODE_WRITE);
   assign rdHit = req.rd && (req.chipCode == `SRO_CODE_READ);

   // ------------------------------------------------------------------------
   // Register writes and frame transfer
   // ------------------------------------------------------------------------
   always_comb begin
      shadow_nxt = shadow_r;
      fixA_nxt   = fixA_r;
      fixB_nxt   = fixB_r;
      tune_nxt   = tune_r;
      hold_nxt   = hold_r;
      if (wrHit) begin
         unique case (req.addr)
            `SRO_ADDR_HOLD: hold_nxt = req.wdata[`SRO_BIT_HOLD];
            `SRO_ADDR_RES:  shadow_nxt.convResolutionSel = req.wdata[`SRO_BIT_RES];
            `SRO_ADDR_FIXA: fixA_nxt = req.wdata;
            `SRO_ADDR_DIR: begin
               shadow_nxt.verticalFlip   = req.wdata[`SRO_BIT_VFLIP];
               shadow_nxt.horizontalFlip = req.wdata[`SRO_BIT_HFLIP];
               // An illegal window code would leave the readout undefined, so it is dropped.
               if (req.wdata[`SRO_WIN_MSB:`SRO_WIN_LSB] == `SRO_WIN_FULL ||
                   req.wdata[`SRO_WIN_MSB:`SRO_WIN_LSB] == `SRO_WIN_720 ||
                   req.wdata[`SRO_WIN_MSB:`SRO_WIN_LSB] == `SRO_WIN_CROP) begin
                  shadow_nxt.windowSelect = req.wdata[`SRO_WIN_MSB:`SRO_WIN_LSB];
               end
            end
            `SRO_ADDR_FIXB: fixB_nxt = req.wdata;
            `SRO_ADDR_RATE: begin
               shadow_nxt.rateSelect     = req.wdata[`SRO_RATE_MSB:0];
               shadow_nxt.convGainSelect = req.wdata[`SRO_BIT_CGAIN];
            end
            `SRO_ADDR_BLKL: shadow_nxt.blackOffset[7:0] = req.wdata;
            `SRO_ADDR_BLKH: shadow_nxt.blackOffset[8] = req.wdata[`SRO_BIT_BLKHI];
            `SRO_ADDR_TUNE: tune_nxt = req.wdata;
            `SRO_ADDR_GAIN: shadow_nxt.totalGain = req.wdata;
            default: ;
         endcase
      end
   end

   // A write in the same cycle as a frame boundary lands one frame later.
   always_comb begin
      active_nxt = active_r;
      if (frameStart && !hold_r) begin
         active_nxt = shadow_r;
      end
   end

   // ------------------------------------------------------------------------
   // Read-back of the pending values
   // ------------------------------------------------------------------------
   always_comb begin
      rdValid_nxt = rdHit;
      rdData_nxt  = 8'h00;
      if (rdHit) begin
         unique case (req.addr)
            `SRO_ADDR_HOLD: rdData_nxt = {7'h00, hold_r};
            `SRO_ADDR_RES:  rdData_nxt = {7'h00, shadow_r.convResolutionSel};
            `SRO_ADDR_FIXA: rdData_nxt = fixA_r;
            `SRO_ADDR_DIR:  rdData_nxt = {1'b0, shadow_r.windowSelect, 2'h0,
                                          shadow_r.horizontalFlip, shadow_r.verticalFlip};
            `SRO_ADDR_FIXB: rdData_nxt = fixB_r;
            `SRO_ADDR_RATE: rdData_nxt = {3'h0, shadow_r.convGainSelect, 2'h0, shadow_r.rateSelect};
            `SRO_ADDR_BLKL: rdData_nxt = shadow_r.blackOffset[7:0];
            `SRO_ADDR_BLKH: rdData_nxt = {7'h00, shadow_r.blackOffset[8]};
            `SRO_ADDR_TUNE: rdData_nxt = tune_r;
            `SRO_ADDR_GAIN: rdData_nxt = shadow_r.totalGain;
            default:        rdData_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         shadow_r  <= '{`SRO_RST_RES, `SRO_RST_FLIP, `SRO_RST_FLIP, `SRO_RST_WIN,
                        `SRO_RST_RATE, `SRO_RST_CGAIN, `SRO_RST_BLK, `SRO_RST_GAIN};
         active_r  <= '{`SRO_RST_RES, `SRO_RST_FLIP, `SRO_RST_FLIP, `SRO_RST_WIN,
                        `SRO_RST_RATE, `SRO_RST_CGAIN, `SRO_RST_BLK, `SRO_RST_GAIN};
         fixA_r    <= `SRO_RST_FIXA;
         fixB_r    <= `SRO_RST_FIXB;
         tune_r    <= `SRO_RST_TUNE;
         hold_r    <= `SRO_RST_HOLD;
         rdData_r  <= 8'h00;
         rdValid_r <= 1'b0;
      end else begin
         shadow_r  <= shadow_nxt;
         active_r  <= active_nxt;
         fixA_r    <= fixA_nxt;
         fixB_r    <= fixB_nxt;
         tune_r    <= tune_nxt;
         hold_r    <= hold_nxt;
         rdData_r  <= rdData_nxt;
         rdValid_r <= rdValid_nxt;
      end
   end

   assign rdData      = rdData_r;
   assign rdValid     = rdValid_r;
   assign holdActive  = hold_r;
   assign tuningValue = tune_r;
   assign settings    = active_r;

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   property p_wrong_code_ignored;
      req.wr && req.chipCode != `SRO_CODE_WRITE |=> $stable(shadow_r) && $stable(tune_r);
   endproperty
   a_wrong_code_ignored: assert property (p_wrong_code_ignored)
      else $error("Write with a wrong bank code changed a register.");

   property p_read_answer;
      req.rd |=> rdValid == ($past(req.chipCode) == `SRO_CODE_READ);
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("Read answer does not match the bank code.");

   property p_res_readback;
      rdHit && req.addr == `SRO_ADDR_RES |=> rdData == {7'h00, $past(shadow_r.convResolutionSel)};
   endproperty
   a_res_readback: assert property (p_res_readback)
      else $error("Resolution read-back wrong.");

   property p_flip_pending;
      wrHit && req.addr == `SRO_ADDR_DIR ##1 frameStart && !hold_r |=>
         settings.verticalFlip == $past(req.wdata[`SRO_BIT_VFLIP], 2) &&
         settings.horizontalFlip == $past(req.wdata[`SRO_BIT_HFLIP], 2);
   endproperty
   a_flip_pending: assert property (p_flip_pending)
      else $error("Flip bits not applied at the frame boundary.");

   property p_window_legal;
      settings.windowSelect == `SRO_WIN_FULL || settings.windowSelect == `SRO_WIN_720 ||
      settings.windowSelect == `SRO_WIN_CROP;
   endproperty
   a_window_legal: assert property (p_window_legal)
      else $error("Illegal window code became active.");

   property p_rate_gain_write;
      wrHit && req.addr == `SRO_ADDR_RATE |=> shadow_r.rateSelect == $past(req.wdata[1:0]) &&
         shadow_r.convGainSelect == $past(req.wdata[`SRO_BIT_CGAIN]);
   endproperty
   a_rate_gain_write: assert property (p_rate_gain_write)
      else $error("Rate or gain mode write lost.");

   property p_black_high;
      wrHit && req.addr == `SRO_ADDR_BLKH |=> shadow_r.blackOffset[8] == $past(req.wdata[0]) &&
         $stable(shadow_r.blackOffset[7:0]);
   endproperty
   a_black_high: assert property (p_black_high)
      else $error("Black offset top bit write wrong.");

   property p_gain_write;
      wrHit && req.addr == `SRO_ADDR_GAIN |=> shadow_r.totalGain == $past(req.wdata);
   endproperty
   a_gain_write: assert property (p_gain_write)
      else $error("Gain write lost.");

   property p_hold_freezes;
      hold_r || !frameStart |=> $stable(settings);
   endproperty
   a_hold_freezes: assert property (p_hold_freezes)
      else $error("Settings changed while held or between frames.");

   property p_transfer;
      frameStart && !hold_r |=> settings == $past(shadow_r);
   endproperty
   a_transfer: assert property (p_transfer)
      else $error("Pending settings not transferred at the frame boundary.");

   c_held_frame:  cover property (hold_r && frameStart);
   c_gain_apply:  cover property (wrHit && req.addr == `SRO_ADDR_GAIN ##[1:20] frameStart && !hold_r);
   c_read_window: cover property (rdHit && req.addr == `SRO_ADDR_DIR);
   c_write_frame: cover property (wrHit && frameStart && !hold_r);

endmodule

// ===== sro_host.sv
// ----------------------------------------------------------------------------
// Host controller model on the decoded control port
// ----------------------------------------------------------------------------
module sro_host (
   input  wire logic              sys_clk,
   output sro_pkg::sro_req_t      req
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      req = '0;
   end

   // A wrong bank code is sent only when a scenario asks for a refusal.
   // Released code, address and data lines show the inverse of the last value and both strobes drop to 0, so a stale address is never mistaken for a live one.
   task automatic access(input logic isWr, input logic [15:0] addr, input logic [7:0] data, input logic badCode);
      @(posedge sys_clk);
      #1;
      req.wr = isWr;
      req.rd = !isWr;
      req.chipCode = (isWr ^ badCode) ? 8'h02 : 8'h82;
      req.addr = addr;
      req.wdata = data;
      @(posedge sys_clk);
      #1;
      req.wr = 1'b0;
      req.rd = 1'b0;
      req.chipCode = ~req.chipCode;
      req.addr = ~addr;
      req.wdata = ~data;
   endtask
endmodule

// ===== test_sensor_readout_config_regs.sv
module test_sensor_readout_config_regs;
   timeunit 1ns;
   timeprecision 100ps;

   logic                   sys_clk;
   logic                   resetn;
   logic                   frameStart;
   logic [7:0]             rdData;
   logic                   rdValid;
   logic                   holdActive;
   logic [7:0]             tuningValue;
   sro_pkg::sro_req_t      req;
   sro_pkg::sro_settings_t settings;
   sro_pkg::sro_settings_t act;
   logic [7:0]             sh [0:31];
   logic [31:0]            seed;
   logic [2:0]             winTab [0:2];
   int                     mismatches;
   int                     n_tests;

   sro_config_regs sro_config_regs_inst (.sys_clk(sys_clk), .resetn(resetn), .req(req), .frameStart(frameStart),
      .rdData(rdData), .rdValid(rdValid), .holdActive(holdActive), .tuningValue(tuningValue), .settings(settings));
   sro_host sro_host_inst (.sys_clk(sys_clk), .req(req));

   // ----------------------------------------------------------------------------
   // Expectation helpers
   // ----------------------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Fixed and reserved bits read back as 0; unmapped bytes read 00h.
   function automatic logic [7:0] msk(input logic [4:0] a);
      case (a)
         5'h01, 5'h05, 5'h0b: return 8'h01;
         5'h07: return 8'h73;
         5'h09: return 8'h13;
         5'h06, 5'h08, 5'h0a, 5'h11, 5'h14: return 8'hff;
         default: return 8'h00;
      endcase
   endfunction

   function automatic sro_pkg::sro_settings_t fromSh();
      return {sh[5][0], sh[7][0], sh[7][1], sh[7][6:4], sh[9][1:0], sh[9][4], sh[11][0], sh[10], sh[20]};
   endfunction

   task automatic initModel();
      foreach (sh[i]) sh[i] = 8'h00;
      sh[5]  = 8'h01;
      sh[8]  = 8'ha0;
      sh[9]  = 8'h01;
      sh[10] = 8'hf0;
      act    = fromSh();
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------------
   // Port tasks
   // ----------------------------------------------------------------------------
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bad);
      sro_host_inst.access(1'b1, a, d, bad);
      if (!bad) begin
         if (a[4:0] == 5'h07 && d[6:4] != 3'h0 && d[6:4] != 3'h1 && d[6:4] != 3'h4) begin
            d[6:4] = sh[7][6:4];
         end
         sh[a[4:0]] = d & msk(a[4:0]);
      end
   endtask

   task automatic rd(input logic [15:0] a, input logic bad);
      sro_host_inst.access(1'b0, a, 8'h00, bad);
      chk(rdValid, !bad);
      chk(rdData, bad ? 8'h00 : sh[a[4:0]]);
   endtask

   // The model is read at the sampling edge itself, so a write landing on that edge is not yet in it.
   task automatic frame(input int lead);
      logic                   held;
      sro_pkg::sro_settings_t nxt;
      repeat (lead + 1) @(posedge sys_clk);
      #1;
      frameStart = 1'b1;
      @(posedge sys_clk);
      held = sh[1][0];
      nxt  = fromSh();
      #1;
      frameStart = 1'b0;
      if (!held) begin
         act = nxt;
      end
      chk(settings, act);
   endtask

   // ----------------------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   initial begin
      #80000;
      mismatches++;
      summarize();
   end

   initial begin
      seed = 32'h4b;
      winTab = '{3'h0, 3'h1, 3'h4};
      mismatches = 0;
      n_tests = 0;
      resetn = 1'b0;
      frameStart = 1'b0;
      initModel();
      repeat (12) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      chk(settings, act);
      chk(holdActive, 1'b0);
      chk(tuningValue, 8'h00);
      for (int a = 16'h3001; a <= 16'h3015; a++) rd(a[15:0], 1'b0);
      rd(16'h3014, 1'b1);
      wr(16'h3014, 8'h55, 1'b1);
      rd(16'h3014, 1'b0);
      for (int i = 0; i < 20; i++) begin
         wr(16'h3005, 8'(rnd()), 1'b0);
         wr(16'h3007, 8'({1'b0, winTab[rnd() % 3], 4'h0} | (rnd() & 8'h03)), 1'b0);
         wr(16'h3009, 8'(rnd()), 1'b0);
         wr(16'h300a, 8'(rnd()), 1'b0);
         wr(16'h300b, 8'(rnd()), 1'b0);
         wr(16'h3014, 8'(rnd()), 1'b0);
         rd(16'h300b, 1'b0);
         rd(16'h3007, 1'b0);
         chk(settings, act);
         frame(0);
      end
      wr(16'h3007, 8'h23, 1'b0);
      rd(16'h3007, 1'b0);
      frame(0);
      wr(16'h3001, 8'h01, 1'b0);
      chk(holdActive, 1'b1);
      wr(16'h3014, 8'hc7, 1'b0);
      frame(0);
      wr(16'h3001, 8'h00, 1'b0);
      frame(0);
      // A write on the edge just before a frame boundary must make that frame.
      fork
         wr(16'h3007, 8'h42, 1'b0);
         frame(1);
      join
      // A write on the frame boundary itself waits for the following frame.
      fork
         wr(16'h3014, 8'h3c, 1'b0);
         frame(0);
      join
      frame(0);
      wr(16'h3011, 8'h0a, 1'b0);
      chk(tuningValue, 8'h0a);
      wr(16'h3006, 8'h00, 1'b0);
      wr(16'h3008, 8'ha0, 1'b0);
      rd(16'h3008, 1'b0);
      wr(16'h3001, 8'h01, 1'b0);
      // A reset in mid-run must drop the hold and every pending and active value.
      @(posedge sys_clk);
      #1;
      resetn = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      initModel();
      chk(settings, act);
      chk(holdActive, 1'b0);
      chk(tuningValue, 8'h00);
      rd(16'h3014, 1'b0);
      rd(16'h3007, 1'b0);
      summarize();
   end
endmodule
